// File: slc_pkg.sv
// constants shared by the serial line command handler
package slc_pkg;
  // host command opcodes (message byte 0)
  localparam logic [7:0] OP_DTR_ON   = 8'h09;
  localparam logic [7:0] OP_GATE_SET = 8'h0A;
  localparam logic [7:0] OP_GATE_CLR = 8'h0B;
  localparam logic [7:0] OP_DSR_ON   = 8'h0C;
  localparam logic [7:0] OP_DSR_OFF  = 8'h0D;
  localparam logic [7:0] OP_RI_ON    = 8'h0E;
  localparam logic [7:0] OP_RI_OFF   = 8'h0F;
  localparam logic [7:0] OP_DTR_OFF  = 8'h10;
  localparam logic [7:0] OP_BRK_ON   = 8'h11;
  localparam logic [7:0] OP_BRK_OFF  = 8'h12;
  localparam logic [7:0] OP_LOAD     = 8'h13;
  localparam logic [7:0] OP_EXEC     = 8'h14;
  localparam logic [7:0] OP_RELEASE  = 8'h15;
  // device to host message codes
  localparam logic [7:0] MSG_INPUT   = 8'h02;
  localparam logic [7:0] MSG_LOADED  = 8'h03;
  localparam logic [7:0] MSG_CD_ON   = 8'h04;
  localparam logic [7:0] MSG_CD_OFF  = 8'h05;
  localparam logic [7:0] MSG_DSR_ON  = 8'h09;
  localparam logic [7:0] MSG_DSR_OFF = 8'h0A;
  localparam logic [7:0] MSG_RI      = 8'h0B;
  // source offsets in a download carry this bias
  localparam logic [15:0] SRC_BIAS   = 16'h4000;
  // bit positions of command fields inside the 128-bit message
  localparam int POS_LINE = 8;
  localparam int POS_DOFF = 16;
  localparam int POS_DSEL = 32;
  localparam int POS_SRC  = 48;
  localparam int POS_SIZE = 64;
  localparam int POS_RCNT = 16;
  // register byte offsets
  localparam logic [7:0] ADDR_CMD0    = 8'h00;
  localparam logic [7:0] ADDR_CMD3    = 8'h0C;
  localparam logic [7:0] ADDR_DOORBEL = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h14;
  localparam logic [7:0] ADDR_LSTAT0  = 8'h18;
  localparam logic [7:0] ADDR_LSTAT1  = 8'h1C;
  localparam logic [7:0] ADDR_RSP0    = 8'h20;
  localparam logic [7:0] ADDR_RSP3    = 8'h2C;
  localparam logic [7:0] ADDR_RSPCTL  = 8'h30;
  // values after reset
  localparam logic [7:0] RST_ACTIVE   = 8'hFF;
  // bus answers
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;
endpackage : slc_pkg

// File: slc_sync.sv
// two flip-flop synchroniser for a vector of pin levels
module slc_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : slc_sync

// File: slc_handler.sv
// serial line command interpreter with an axi4-lite register slave
// Behaviour
// - opcode 09h raises DTR on line
// - DTR raise with carrier up reports carrier
// - opcode 0Ah gates transmit by CTS, receive by CD
// - opcode 0Bh removes gating; ungated after reset
// - opcode 0Ch enables DSR change reports
// - opcode 0Dh disables DSR reports; reset default
// - opcode 0Eh enables RI change reports
// - opcode 0Fh disables RI change reports
// - opcode 10h drops DTR, no reply
// - opcode 11h holds transmit at spacing
// - break start ignored while line transmits
// - opcode 12h ends break, no reply
// - opcode 13h copies bytes, then reports done
// - opcode 14h jumps to start address
// - opcode 15h frees received characters
// - one input-available message per line outstanding
// - release without outstanding message ignored
// - carrier rise sends code 04h message
// - pending input sent as code 02h
// - DSR changes reported when enabled
// - download completion sent as code 03h
module slc_handler #(
  parameter int NUM_LINES = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [NUM_LINES-1:0]   cdIn,
  input  wire logic [NUM_LINES-1:0]   ctsIn,
  input  wire logic [NUM_LINES-1:0]   dsrIn,
  input  wire logic [NUM_LINES-1:0]   riIn,
  input  wire logic [NUM_LINES-1:0]   txBusy,
  input  wire logic [NUM_LINES*16-1:0] rxCount,
  input  wire logic [NUM_LINES*16-1:0] rxOffset,
  output logic [NUM_LINES-1:0]        dtrOut,
  output logic [NUM_LINES-1:0]        breakOut,
  output logic [NUM_LINES-1:0]        txEnable,
  output logic [NUM_LINES-1:0]        rxEnable,
  output logic [NUM_LINES-1:0]        rxRelease,
  output logic [15:0]                 rxRelCount,
  output logic                        memRdEn,
  output logic [15:0]                 memRdAddr,
  input  wire logic [7:0]             memRdData,
  output logic                        memWrEn,
  output logic [19:0]                 memWrAddr,
  output logic [7:0]                  memWrData,
  output logic                        jumpStrobe,
  output logic [19:0]                 jumpAddr
);
  localparam int N  = NUM_LINES;
  localparam int LW = (N > 1) ? $clog2(N) : 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WT   = 2'b10,
    ST_WR   = 2'b11
  } slc_state_t;

  slc_state_t     st_r;
  logic [127:0]   cmd_r, rsp_r, rspNxt;
  logic           cmdPend_r, rspValid_r;
  logic [N-1:0]   active_r, gate_r, dsrRep_r, riRep_r, out_r;
  logic [N-1:0]   cdS, ctsS, dsrS, riS, cdD, dsrD, riD, rxNz;
  logic [N-1:0]   cdOnP_r, cdOffP_r, dsrOnP_r, dsrOffP_r, riP_r, rxP_r;
  logic [N-1:0]   anyP, lineSel, sendSel;
  logic [5:0]     take;
  logic           dlP_r, dlSet, sendGo, execGo, lineOk;
  logic [LW-1:0]  lineIdx, sendLine;
  logic [7:0]     opc, lineNum;
  logic [15:0]    rem_r, src_r;
  logic [19:0]    dst_r;
  logic           awHeld_r, wHeld_r, wrDo;
  logic [7:0]     awAddr_r;
  logic [31:0]    wData_r, rdMux;
  logic [3:0]     wStrb_r;

  // pin levels cross into the board clock before use
  slc_sync #(.W(4*N)) pinSync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({cdIn, ctsIn, dsrIn, riIn}),
    .q     ({cdS, ctsS, dsrS, riS})
  );

  // command decode fields
  assign execGo  = (st_r == ST_IDLE) && cmdPend_r;
  assign opc     = cmd_r[7:0];
  assign lineNum = cmd_r[slc_pkg::POS_LINE +: 8];
  assign lineIdx = lineNum[LW-1:0];
  assign lineOk  = (32'(lineNum) < N) && active_r[lineIdx];
  assign lineSel = {{(N-1){1'b0}}, 1'b1} << lineIdx;

  // axi write address and data are latched in either order
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end else begin
      awready <= awvalid && !awready && !awHeld_r && !bvalid;
      wready  <= wvalid && !wready && !wHeld_r && !bvalid;
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (wrDo) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (wrDo) begin
        wHeld_r <= 1'b0;
      end
    end
  end
  assign wrDo = awHeld_r && wHeld_r && !bvalid;

  // write response; unmapped offsets answer slverr
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp  <= slc_pkg::RESP_OKAY;
    end else if (wrDo) begin
      bvalid <= 1'b1;
      bresp  <= (awAddr_r <= slc_pkg::ADDR_RSPCTL && awAddr_r[1:0] == 2'b00)
                ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // register writes: message words, doorbell, active mask
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r     <= '0;
      cmdPend_r <= 1'b0;
      active_r  <= N'(slc_pkg::RST_ACTIVE);
    end else begin
      if (execGo) begin
        cmdPend_r <= 1'b0;
      end
      if (wrDo && awAddr_r <= slc_pkg::ADDR_CMD3 && !cmdPend_r) begin
        for (int b = 0; b < 4; b++) begin
          if (wStrb_r[b]) begin
            cmd_r[{awAddr_r[3:2], 5'h00} + 7'(8*b) +: 8] <= wData_r[8*b +: 8];
          end
        end
      end
      // a posted message is frozen until the interpreter takes it
      if (wrDo && awAddr_r == slc_pkg::ADDR_DOORBEL && wData_r[0]) begin
        cmdPend_r <= 1'b1;
      end
      if (wrDo && awAddr_r == slc_pkg::ADDR_ACTIVE) begin
        active_r <= wData_r[N-1:0];
      end
    end
  end

  // read path; mux then register
  always_comb begin
    rdMux = 32'h0000_0000;
    case (araddr)
      8'h00, 8'h04, 8'h08, 8'h0C: rdMux = cmd_r[{araddr[3:2], 5'h00} +: 32];
      slc_pkg::ADDR_DOORBEL: rdMux = {31'h0000_0000, cmdPend_r};
      slc_pkg::ADDR_ACTIVE:  rdMux = 32'(active_r);
      slc_pkg::ADDR_LSTAT0:  rdMux = {8'(dsrRep_r), 8'(gate_r),
                                      8'(breakOut), 8'(dtrOut)};
      slc_pkg::ADDR_LSTAT1:  rdMux = {16'h0000, 8'(out_r), 8'(riRep_r)};
      8'h20, 8'h24, 8'h28, 8'h2C: rdMux = rsp_r[{araddr[3:2], 5'h00} +: 32];
      slc_pkg::ADDR_RSPCTL:  rdMux = {31'h0000_0000, rspValid_r};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= slc_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdMux;
        rresp  <= (araddr <= slc_pkg::ADDR_RSPCTL && araddr[1:0] == 2'b00)
                  ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // per-line modem and gating state driven by line commands
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dtrOut   <= '0;
      breakOut <= '0;
      gate_r   <= '0;
      dsrRep_r <= '0;
      riRep_r  <= '0;
    end else if (execGo && lineOk) begin
      case (opc)
        slc_pkg::OP_DTR_ON:   dtrOut[lineIdx]   <= 1'b1;
        slc_pkg::OP_DTR_OFF:  dtrOut[lineIdx]   <= 1'b0;
        slc_pkg::OP_GATE_SET: gate_r[lineIdx]   <= 1'b1;
        slc_pkg::OP_GATE_CLR: gate_r[lineIdx]   <= 1'b0;
        slc_pkg::OP_DSR_ON:   dsrRep_r[lineIdx] <= 1'b1;
        slc_pkg::OP_DSR_OFF:  dsrRep_r[lineIdx] <= 1'b0;
        slc_pkg::OP_RI_ON:    riRep_r[lineIdx]  <= 1'b1;
        slc_pkg::OP_RI_OFF:   riRep_r[lineIdx]  <= 1'b0;
        slc_pkg::OP_BRK_ON: begin
          // a frame already on the wire is not cut short
          if (!txBusy[lineIdx]) begin
            breakOut[lineIdx] <= 1'b1;
          end
        end
        slc_pkg::OP_BRK_OFF:  breakOut[lineIdx] <= 1'b0;
        default: ;
      endcase
    end
  end

  // gates; transmitter idle logic sees txEnable low while gated off
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txEnable <= '1;
      rxEnable <= '1;
    end else begin
      txEnable <= ~gate_r | ctsS;
      rxEnable <= ~gate_r | cdS;
    end
  end

  // delayed copies for edge detection, taken from the synced levels
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cdD  <= '0;
      dsrD <= '0;
      riD  <= '0;
    end else begin
      cdD  <= cdS;
      dsrD <= dsrS;
      riD  <= riS;
    end
  end

  // a line has input waiting when its receive count is nonzero
  for (genvar i = 0; i < N; i++) begin : gRx
    assign rxNz[i] = rxCount[16*i +: 16] != 16'h0000;
  end

  // pending events; a new event wins over the take in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cdOnP_r   <= '0;
      cdOffP_r  <= '0;
      dsrOnP_r  <= '0;
      dsrOffP_r <= '0;
      riP_r     <= '0;
      rxP_r     <= '0;
      dlP_r     <= 1'b0;
    end else begin
      cdOnP_r   <= (cdOnP_r & ~(sendSel & {N{take[0]}})) | (cdS & ~cdD)
                   | ((execGo && lineOk && opc == slc_pkg::OP_DTR_ON)
                      ? (lineSel & cdS) : '0);
      cdOffP_r  <= (cdOffP_r & ~(sendSel & {N{take[1]}})) | (~cdS & cdD);
      dsrOnP_r  <= (dsrOnP_r & ~(sendSel & {N{take[2]}}))
                   | (dsrS & ~dsrD & dsrRep_r);
      dsrOffP_r <= (dsrOffP_r & ~(sendSel & {N{take[3]}}))
                   | (~dsrS & dsrD & dsrRep_r);
      riP_r     <= (riP_r & ~(sendSel & {N{take[4]}}))
                   | ((riS ^ riD) & riRep_r);
      rxP_r     <= (rxP_r & ~(sendSel & {N{take[5]}}))
                   | (rxNz & ~out_r & ~rxP_r);
      dlP_r     <= (dlP_r && !(sendGo && dlP_r)) || dlSet;
    end
  end

  // pick lowest line with a pending event, then event kind by priority
  assign anyP   = cdOnP_r | cdOffP_r | dsrOnP_r | dsrOffP_r | riP_r | rxP_r;
  assign sendGo = !rspValid_r && (dlP_r || (|anyP));
  assign sendSel = {{(N-1){1'b0}}, 1'b1} << sendLine;
  always_comb begin
    sendLine = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (anyP[i]) begin
        sendLine = LW'(i);
      end
    end
  end

  always_comb begin
    take   = 6'h00;
    rspNxt = {120'h0, slc_pkg::MSG_LOADED};
    if (sendGo && !dlP_r) begin
      if (cdOnP_r[sendLine]) begin
        take[0] = 1'b1;
        rspNxt  = {112'h0, 8'(sendLine), slc_pkg::MSG_CD_ON};
      end else if (cdOffP_r[sendLine]) begin
        take[1] = 1'b1;
        rspNxt  = {112'h0, 8'(sendLine), slc_pkg::MSG_CD_OFF};
      end else if (dsrOnP_r[sendLine]) begin
        take[2] = 1'b1;
        rspNxt  = {112'h0, 8'(sendLine), slc_pkg::MSG_DSR_ON};
      end else if (dsrOffP_r[sendLine]) begin
        take[3] = 1'b1;
        rspNxt  = {112'h0, 8'(sendLine), slc_pkg::MSG_DSR_OFF};
      end else if (riP_r[sendLine]) begin
        take[4] = 1'b1;
        rspNxt  = {112'h0, 8'(sendLine), slc_pkg::MSG_RI};
      end else begin
        take[5] = 1'b1;
        rspNxt  = {80'h0, rxOffset[16*sendLine +: 16],
                   rxCount[16*sendLine +: 16], 8'(sendLine),
                   slc_pkg::MSG_INPUT};
      end
    end
  end

  // outgoing message slot; host acks it through the response control
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_r      <= '0;
      rspValid_r <= 1'b0;
    end else if (sendGo) begin
      rsp_r      <= rspNxt;
      rspValid_r <= 1'b1;
    end else if (wrDo && awAddr_r == slc_pkg::ADDR_RSPCTL && wData_r[0]) begin
      rspValid_r <= 1'b0;
    end
  end

  // outstanding input messages and receive buffer release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_r      <= '0;
      rxRelease  <= '0;
      rxRelCount <= 16'h0000;
    end else begin
      rxRelease <= '0;
      if (execGo && lineOk && opc == slc_pkg::OP_RELEASE
          && out_r[lineIdx]) begin
        rxRelease  <= lineSel;
        rxRelCount <= cmd_r[slc_pkg::POS_RCNT +: 16];
      end
      // the send sets after the clear so a new message is never lost
      out_r <= (out_r & ~((execGo && lineOk && opc == slc_pkg::OP_RELEASE)
               ? lineSel : '0)) | (sendSel & {N{take[5]}});
    end
  end

  // download copy engine and execute jump
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r       <= ST_IDLE;
      rem_r      <= 16'h0000;
      src_r      <= 16'h0000;
      dst_r      <= 20'h00000;
      dlSet      <= 1'b0;
      memRdEn    <= 1'b0;
      memRdAddr  <= 16'h0000;
      memWrEn    <= 1'b0;
      memWrAddr  <= 20'h00000;
      memWrData  <= 8'h00;
      jumpStrobe <= 1'b0;
      jumpAddr   <= 20'h00000;
    end else begin
      dlSet      <= 1'b0;
      memRdEn    <= 1'b0;
      memWrEn    <= 1'b0;
      jumpStrobe <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (execGo && opc == slc_pkg::OP_LOAD) begin
            src_r <= cmd_r[slc_pkg::POS_SRC +: 16] - slc_pkg::SRC_BIAS;
            dst_r <= {cmd_r[slc_pkg::POS_DSEL +: 16], 4'h0}
                     + {4'h0, cmd_r[slc_pkg::POS_DOFF +: 16]};
            rem_r <= cmd_r[slc_pkg::POS_SIZE +: 16];
            st_r  <= ST_RD;
          end else if (execGo && opc == slc_pkg::OP_EXEC) begin
            jumpStrobe <= 1'b1;
            jumpAddr   <= {cmd_r[slc_pkg::POS_DSEL +: 16], 4'h0}
                          + {4'h0, cmd_r[slc_pkg::POS_DOFF +: 16]};
          end
        end
        ST_RD: begin
          if (rem_r == 16'h0000) begin
            dlSet <= 1'b1;
            st_r  <= ST_IDLE;
          end else begin
            memRdEn   <= 1'b1;
            memRdAddr <= src_r;
            st_r      <= ST_WT;
          end
        end
        ST_WT: st_r <= ST_WR;                            // memory samples here
        ST_WR: begin
          memWrEn   <= 1'b1;
          memWrData <= memRdData;
          memWrAddr <= dst_r;
          src_r     <= src_r + 16'h0001;
          dst_r     <= dst_r + 20'h00001;
          rem_r     <= rem_r - 16'h0001;
          st_r      <= ST_RD;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // checks
  sequence copyStep;
    (st_r == ST_RD && rem_r != 16'h0000) ##1 memRdEn ##1 (st_r == ST_WR);
  endsequence
  sequence dtrCmd;
    execGo && lineOk && opc == slc_pkg::OP_DTR_ON;
  endsequence

  dtr_assert_a: assert property (@(posedge mclk) disable iff (!rst_b)
    dtrCmd |=> dtrOut[$past(lineIdx)]) else $error("dtr not raised");
  cd_echo_a: assert property (@(posedge mclk) disable iff (!rst_b)
    dtrCmd ##0 cdS[lineIdx] |=> cdOnP_r[$past(lineIdx)])
    else $error("carrier echo missing");
  tx_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (gate_r & ~ctsS) != '0 |=> (txEnable & $past(gate_r & ~ctsS)) == '0)
    else $error("transmit not gated");
  brk_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
    execGo && opc == slc_pkg::OP_BRK_ON && txBusy[lineIdx]
    && !breakOut[lineIdx] |=> !breakOut[$past(lineIdx)])
    else $error("break started during transmit");
  one_avail_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxP_r & out_r) == '0) else $error("second input message pending");
  rel_ignore_a: assert property (@(posedge mclk) disable iff (!rst_b)
    execGo && opc == slc_pkg::OP_RELEASE && !out_r[lineIdx]
    |=> rxRelease == '0) else $error("release without message");
  copy_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    copyStep |=> memWrEn && memWrData == $past(memRdData))
    else $error("copy byte not written");
  load_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == ST_RD && rem_r == 16'h0000 |=> ##1 dlP_r || rspValid_r)
    else $error("download completion lost");
  jump_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    execGo && opc == slc_pkg::OP_EXEC |=> jumpStrobe ##1 !jumpStrobe)
    else $error("jump strobe wrong");
  bad_line_a: assert property (@(posedge mclk) disable iff (!rst_b)
    execGo && !lineOk |=> $stable(dtrOut) && $stable(gate_r))
    else $error("bad line changed state");
endmodule : slc_handler

// File: slc_mem_model.sv
// dual-port ram stand-in that feeds the download copy
module slc_mem_model (
  input  wire logic        mclk,
  input  wire logic        memRdEn,
  input  wire logic [15:0] memRdAddr,
  output logic      [7:0]  memRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  // data lands at the read edge and holds, as the real ram does
  always_ff @(posedge mclk) begin
    if (memRdEn) begin
      memRdData <= memRdAddr[7:0] ^ 8'hA5;
    end
  end
endmodule : slc_mem_model

// File: serial_line_command_handler_tb.sv
// self-checking bench for the serial line command handler
module serial_line_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, memRdEn;
  logic         memWrEn, jumpStrobe;
  logic [7:0]   awaddr, araddr, cdIn, ctsIn, dsrIn, riIn, txBusy;
  logic [7:0]   dtrOut, breakOut, txEnable, rxEnable, rxRelease;
  logic [7:0]   memRdData, memWrData;
  logic [3:0]   wstrb;
  logic [31:0]  wdata, rdata;
  logic [1:0]   bresp, rresp;
  logic [127:0] rxCount, rxOffset;
  logic [15:0]  rxRelCount, memRdAddr, rc;
  logic [19:0]  memWrAddr, jumpAddr;
  logic [33:0]  rq[$], mq[$];
  int           err_count, checks;
  // line 3 command sweep with {lstat1, lstat0} expected after each
  logic [7:0]   ops [9] = '{slc_pkg::OP_GATE_SET, slc_pkg::OP_GATE_CLR,
    slc_pkg::OP_DSR_ON, slc_pkg::OP_DSR_OFF, slc_pkg::OP_BRK_ON,
    slc_pkg::OP_BRK_OFF, slc_pkg::OP_RI_ON, slc_pkg::OP_RI_OFF,
    slc_pkg::OP_DTR_OFF};
  logic [63:0]  exps [9] = '{64'h80008, 64'h8, 64'h8000008, 64'h8,
    64'h808, 64'h8, 64'h8_00000008, 64'h8, 64'h0};

  slc_handler dut (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .cdIn, .ctsIn, .dsrIn,
    .riIn, .txBusy, .rxCount, .rxOffset, .dtrOut, .breakOut, .txEnable,
    .rxEnable, .rxRelease, .rxRelCount, .memRdEn, .memRdAddr, .memRdData,
    .memWrEn, .memWrAddr, .memWrData, .jumpStrobe, .jumpAddr);
  slc_mem_model mem (.mclk, .memRdEn, .memRdAddr, .memRdData);

  // free-running board clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // a bus answer that never comes ends the run as a failure
  task automatic tmo(input int n);
    if (n >= 60) begin
      err_count++;
      results();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq.push_back({slc_pkg::RESP_OKAY, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // response ready stays up between writes, so it is never toggled twice
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 60);
    tmo(n);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 60);
    tmo(n);
  endtask : rd

  // reserved command bytes always go out as zero
  task automatic c(input logic [31:0] w0, w1 = 0, w2 = 0);
    wr(slc_pkg::ADDR_CMD0, w0);
    wr(8'h04, w1);
    wr(8'h08, w2);
    wr(slc_pkg::ADDR_CMD3, 32'h0);
    wr(slc_pkg::ADDR_DOORBEL, 32'h1);
    repeat (14) @(posedge mclk);
  endtask : c

  task automatic msg(input logic [31:0] e);
    rd(slc_pkg::ADDR_RSP0, {2'b00, e});
    wr(slc_pkg::ADDR_RSPCTL, 32'h1);
  endtask : msg

  // read answers and local writes are matched against the oldest note
  always @(posedge mclk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (memWrEn) chk({6'h0, memWrAddr, memWrData}, mq.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, rq.pop_front());
    if (|rxRelease) chk({26'h0, rxRelease}, mq.pop_front());
  end

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
    {awaddr, araddr, wdata, cdIn, ctsIn, dsrIn, riIn, txBusy} = '0;
    {rxCount, rxOffset} = '0;
    void'($urandom(62767));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    wstrb <= 4'hF;
    @(posedge mclk);
    rd(slc_pkg::ADDR_LSTAT0, 34'h0);
    rd(8'h34, {slc_pkg::RESP_SLVERR, 32'h0});
    // download only straight after reset, above low memory, then jump
    mq.push_back({6'h0, 20'h10004, 8'h10 ^ 8'hA5});
    mq.push_back({6'h0, 20'h10005, 8'h11 ^ 8'hA5});
    c({16'h0004, 8'h0, slc_pkg::OP_LOAD}, {16'h4010, 16'h1000},
      32'h2);
    msg(32'h3);
    c({16'h0024, 8'h0, slc_pkg::OP_EXEC}, 32'h2000);
    chk({14'h0, jumpAddr}, 34'h20024);
    cdIn[3] <= 1'b1;
    repeat (8) @(posedge mclk);
    msg(32'h0304);
    c({16'h0, 8'd3, slc_pkg::OP_DTR_ON});
    msg(32'h0304);
    rd(slc_pkg::ADDR_LSTAT0, 34'h8);
    foreach (ops[i]) begin
      c({16'h0, 8'd3, ops[i]});
      rd(slc_pkg::ADDR_LSTAT0, {2'b00, exps[i][31:0]});
      rd(slc_pkg::ADDR_LSTAT1, {2'b00, exps[i][63:32]});
      // carrier is up on line 3, so receive stays open even when gated
      chk({30'h0, rxEnable[3], txEnable[3], breakOut[3], dtrOut[3]},
        {30'h0, 1'b1, ~exps[i][19], exps[i][11], exps[i][3]});
    end
    txBusy[3] <= 1'b1;
    c({16'h0, 8'd3, slc_pkg::OP_BRK_ON});
    chk({33'h0, breakOut[3]}, 34'h0);
    txBusy[3] <= 1'b0;
    c({16'h0, 8'd9, slc_pkg::OP_DTR_ON});
    wr(slc_pkg::ADDR_ACTIVE, 32'hF7);
    c({16'h0, 8'd3, slc_pkg::OP_DTR_ON});
    rd(slc_pkg::ADDR_RSPCTL, 34'h0);
    chk({26'h0, dtrOut}, 34'h0);
    wr(slc_pkg::ADDR_ACTIVE, 32'hFF);
    rc = 16'($urandom_range(1, 65535));
    rxOffset[15:0] <= 16'h4100;
    rxCount[15:0] <= rc;
    repeat (6) @(posedge mclk);
    rd(slc_pkg::ADDR_RSP0 + 8'h4, 34'h4100);
    msg({rc, 16'h0002});
    rd(slc_pkg::ADDR_RSPCTL, 34'h0);
    rxCount[15:0] <= 16'h0;
    mq.push_back(34'h1);
    c({rc, 8'h0, slc_pkg::OP_RELEASE});
    chk({18'h0, rxRelCount}, {18'h0, rc});
    c({16'h7, 8'h0, slc_pkg::OP_RELEASE});
    chk({18'h0, rxRelCount}, {18'h0, rc});
    // line 2 modem changes are reported once reporting is switched on
    c({16'h0, 8'd2, slc_pkg::OP_DSR_ON});
    dsrIn[2] <= 1'b1;
    repeat (6) @(posedge mclk);
    msg(32'h0209);
    c({16'h0, 8'd2, slc_pkg::OP_RI_ON});
    riIn[2] <= 1'b1;
    repeat (6) @(posedge mclk);
    msg(32'h020B);
    // let the watcher take the last answer before counting leftovers
    @(posedge mclk);
    chk(34'(rq.size() + mq.size()), 34'h0);
    results();
  end
endmodule : serial_line_command_handler_tb
